// [common/mmucr_pkg.sv]
// Purpose: shared constants for the common-ram and page relocation unit
// Assumes: 8-bit register port inside the i/o block, 16-bit processor addresses
// Notes: register map and field layout of the memory manager extension registers
package mmucr_pkg;

  // register addresses in the i/o block
  localparam logic [15:0] MMUCR_ADDR_RAM_CFG = 16'hD506;
  localparam logic [15:0] MMUCR_ADDR_P0_LO = 16'hD507;
  localparam logic [15:0] MMUCR_ADDR_P0_HI = 16'hD508;
  localparam logic [15:0] MMUCR_ADDR_P1_LO = 16'hD509;
  localparam logic [15:0] MMUCR_ADDR_P1_HI = 16'hD50A;
  localparam logic [15:0] MMUCR_ADDR_VERSION = 16'hD50B;

  // ram_sharing_config fields and the pointer high byte bank bit
  localparam int MMUCR_SIZE_LSB = 0;
  localparam int MMUCR_REGION_LSB = 2;
  localparam int MMUCR_VBANK_BIT = 6;
  localparam int MMUCR_PTR_BANK_BIT = 0;

  // reset values
  localparam logic [1:0] MMUCR_SIZE_RST = 2'h0;
  localparam logic [1:0] MMUCR_REGION_RST = 2'h0;
  localparam logic MMUCR_VBANK_RST = 1'b0;
  localparam logic [7:0] MMUCR_PTR_RST = 8'h00;
  // committed page 1 target after reset: page 1 stays in place
  localparam logic [7:0] MMUCR_P1_PAGE_RST = 8'h01;

  // shared size codes, in 1K blocks
  localparam logic [1:0] MMUCR_SIZE_1K = 2'h0;
  localparam logic [1:0] MMUCR_SIZE_4K = 2'h1;
  localparam logic [1:0] MMUCR_SIZE_8K = 2'h2;
  localparam logic [1:0] MMUCR_SIZE_16K = 2'h3;

  // region select bits
  localparam int MMUCR_REGION_BOTTOM = 0;
  localparam int MMUCR_REGION_TOP = 1;

  // decode of the shared size into 1K blocks (6-bit address field)
  function automatic logic [6:0] mmucr_size_blocks(input logic [1:0] code);
    logic [6:0] n;
    n = 7'h01;
    unique case (code)
      MMUCR_SIZE_1K: n = 7'h01;
      MMUCR_SIZE_4K: n = 7'h04;
      MMUCR_SIZE_8K: n = 7'h08;
      MMUCR_SIZE_16K: n = 7'h10;
    endcase
    return n;
  endfunction : mmucr_size_blocks

endpackage : mmucr_pkg

// [logic/mmucr_share_dec.sv]
// Purpose: decides whether a physical address lies in shared common ram
// Assumes: address given as its upper six bits (1K granules)
// Notes: purely combinational
`timescale 1ns/1ps
module mmucr_share_dec
  import mmucr_pkg::*;
(
  input wire logic [5:0] i_addr_k,   // address bits 15:10
  input wire logic [1:0] i_size,     // shared size code
  input wire logic [1:0] i_region,   // region select
  input wire logic i_legacy,         // legacy compatibility mode
  output logic o_hit,                // address is in common ram
  output logic o_bottom_en           // bottom region enabled
);
  logic [6:0] blocks;
  logic [6:0] addr_k;

  always_comb
  begin
    // size ignored in legacy mode: fall back to the smallest area
    blocks = i_legacy ? mmucr_size_blocks(MMUCR_SIZE_1K) : mmucr_size_blocks(i_size);
    addr_k = {1'b0, i_addr_k};
    o_bottom_en = i_region[MMUCR_REGION_BOTTOM];
    o_hit = (o_bottom_en && (addr_k < blocks)) ||
            (i_region[MMUCR_REGION_TOP] && (addr_k >= (7'h40 - blocks)));
  end
endmodule : mmucr_share_dec

// [logic/mmucr_page_xlat.sv]
// Purpose: relocates and swaps processor pages zero and one
// Assumes: committed pointer bytes from the register block
// Notes: purely combinational
`timescale 1ns/1ps
module mmucr_page_xlat
(
  input wire logic [15:0] i_addr,    // processor address
  input wire logic i_is_ram,         // access targets ram
  input wire logic [7:0] i_p0_page,  // page 0 target page
  input wire logic [7:0] i_p1_page,  // page 1 target page
  input wire logic i_p0_bank,        // page 0 bank bit
  input wire logic i_p1_bank,        // page 1 bank bit
  output logic [7:0] o_page,         // translated address bits 15:8
  output logic o_pg01,               // original page is zero or one
  output logic o_bank_ovr,           // pointer bank bit applies
  output logic o_bank                // pointer bank value
);
  logic [7:0] page;

  always_comb
  begin
    page = i_addr[15:8];
    o_page = page;
    o_pg01 = (page == 8'h00) || (page == 8'h01);
    o_bank_ovr = 1'b0;
    o_bank = 1'b0;
    if (i_addr[15:1] == 15'h0000)
    begin
      // bytes 0 and 1 never move
      o_page = 8'h00;
    end
    else if (page == 8'h00)
    begin
      o_page = i_p0_page;
      o_bank_ovr = 1'b1;
      o_bank = i_p0_bank;
    end
    else if (page == 8'h01)
    begin
      o_page = i_p1_page;
      o_bank_ovr = 1'b1;
      o_bank = i_p1_bank;
    end
    else if (i_is_ram && (page == i_p0_page))
    begin
      // swap: target page lands on the original page zero
      o_page = 8'h00;
    end
    else if (i_is_ram && (page == i_p1_page))
    begin
      o_page = 8'h01;
    end
  end
endmodule : mmucr_page_xlat

// [logic/mmucr_top.sv]
// Purpose: common ram sharing, page relocation and version registers
// Assumes: register port and access requests synchronous to i_core_clk
// Notes: translation results appear one cycle after the request
// What this block does
// - bits 1:0 of config at D506 set shared size 1K/4K/8K/16K.
// - size bits ignored in legacy mode; both reset to zero.
// - bits 3:2 pick shared region: none, bottom, top, both.
// - shared-region accesses go to bank 0 instead of bank 1.
// - region bits clear on reset, nothing shared.
// - shared access drives bank 0 strobe low, bank 1 strobe high.
// - config bits 5:4 have no function, reserved.
// - bit 6 picks video bank independently; bit 7 ignored.
// - four pointer bytes at D507..D50A: p0 low, p0 high, p1 low, p1 high.
// - high byte write only held; low byte write commits relocation to bits 15:8.
// - high byte bit 0 picks bank for that page; other bits ignored.
// - page 1 pointer works like page 0; pointer bytes reset to zero, committed page 1 target to 01.
// - addresses 0 and 1 always reach their own locations.
// - relocated target page is swapped back to the original page.
// - back translation only for ram, never rom or i/o.
// - video accesses are never back translated.
// - mapped rom still overrides ram, relocated or not.
// - pointer bank bit overrides config bank for pages zero and one, except addresses 0 and 1.
// - bottom common ram enabled ignores pointer banks, pages in common ram.
// - version register D50B: version in 3:0, 64K block count in 7:4.
// - config loading stays outside; these registers vanish when i/o is off.
`timescale 1ns/1ps
module mmucr_top
  import mmucr_pkg::*;
#(
  parameter logic [3:0] UNIT_VERSION = 4'h1,  // arbitrary value
  parameter logic [3:0] MEM_BLOCKS = 4'h2
)
(
  input wire logic i_core_clk,            // system clock
  input wire logic i_sys_rst,             // synchronous reset, active high
  input wire logic i_io_visible,          // i/o block mapped in
  input wire logic i_legacy_mode,         // legacy compatibility mode
  input wire logic [15:0] i_reg_addr,     // register port address
  input wire logic [7:0] i_reg_wdata,     // register write data
  input wire logic i_reg_wr,              // register write strobe
  input wire logic i_reg_rd,              // register read strobe
  output logic [7:0] o_reg_rdata,         // register read data
  output logic o_reg_rd_hit,              // read answered by this block
  input wire logic i_acc_valid,           // memory access request
  input wire logic [15:0] i_acc_addr,     // access address
  input wire logic i_acc_is_ram,          // access maps to ram
  input wire logic i_acc_video,           // access is a video cycle
  input wire logic i_cfg_bank,            // processor bank from config
  output logic o_acc_valid,               // translated access valid
  output logic [7:0] o_taddr_hi,          // translated address 15:8
  output logic o_bank0_strobe_n,          // bank 0 strobe enable, low active
  output logic o_bank1_strobe_n,          // bank 1 strobe enable, low active
  output logic o_video_bank               // video bank select
);
  import mmucr_pkg::*;

  logic [1:0] size_q;
  logic [1:0] region_q;
  logic vbank_q;
  logic [7:0] p0_lo_q;
  logic [7:0] p0_hi_q;
  logic [7:0] p1_lo_q;
  logic [7:0] p1_hi_q;
  logic [7:0] p0_page_q;
  logic [7:0] p1_page_q;
  logic p0_bank_q;
  logic p1_bank_q;
  logic wr_cfg;
  logic wr_p0_lo;
  logic wr_p0_hi;
  logic wr_p1_lo;
  logic wr_p1_hi;
  logic rd_sel;
  logic [7:0] rd_d;
  logic [7:0] x_page;
  logic x_pg01;
  logic x_ovr;
  logic x_bank;
  logic [7:0] t_page;
  logic share_hit;
  logic bottom_en;
  logic bank_d;
  logic use_bank0;

  // register decode, only while the i/o block is mapped in
  always_comb
  begin
    wr_cfg = i_reg_wr && i_io_visible && (i_reg_addr == MMUCR_ADDR_RAM_CFG);
    wr_p0_lo = i_reg_wr && i_io_visible && (i_reg_addr == MMUCR_ADDR_P0_LO);
    wr_p0_hi = i_reg_wr && i_io_visible && (i_reg_addr == MMUCR_ADDR_P0_HI);
    wr_p1_lo = i_reg_wr && i_io_visible && (i_reg_addr == MMUCR_ADDR_P1_LO);
    wr_p1_hi = i_reg_wr && i_io_visible && (i_reg_addr == MMUCR_ADDR_P1_HI);
    rd_sel = i_reg_rd && i_io_visible &&
             (i_reg_addr >= MMUCR_ADDR_RAM_CFG) && (i_reg_addr <= MMUCR_ADDR_VERSION);
  end

  // ram sharing config; bits 5:4 and 7 are not stored
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      size_q <= MMUCR_SIZE_RST;
      region_q <= MMUCR_REGION_RST;
      vbank_q <= MMUCR_VBANK_RST;
    end
    else if (wr_cfg)
    begin
      size_q <= i_reg_wdata[MMUCR_SIZE_LSB +: 2];
      region_q <= i_reg_wdata[MMUCR_REGION_LSB +: 2];
      vbank_q <= i_reg_wdata[MMUCR_VBANK_BIT];
    end
  end

  // pointer bytes as written, for read back
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      p0_lo_q <= MMUCR_PTR_RST;
      p0_hi_q <= MMUCR_PTR_RST;
      p1_lo_q <= MMUCR_PTR_RST;
      p1_hi_q <= MMUCR_PTR_RST;
    end
    else
    begin
      if (wr_p0_lo)
        p0_lo_q <= i_reg_wdata;
      if (wr_p0_hi)
        p0_hi_q <= i_reg_wdata;
      if (wr_p1_lo)
        p1_lo_q <= i_reg_wdata;
      if (wr_p1_hi)
        p1_hi_q <= i_reg_wdata;
    end
  end

  // committed relocation, taken on the low byte write
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      p0_page_q <= MMUCR_PTR_RST;
      p1_page_q <= MMUCR_P1_PAGE_RST;
      p0_bank_q <= 1'b0;
      p1_bank_q <= 1'b0;
    end
    else
    begin
      if (wr_p0_lo)
      begin
        p0_page_q <= i_reg_wdata;
        p0_bank_q <= p0_hi_q[MMUCR_PTR_BANK_BIT];
      end
      if (wr_p1_lo)
      begin
        p1_page_q <= i_reg_wdata;
        p1_bank_q <= p1_hi_q[MMUCR_PTR_BANK_BIT];
      end
    end
  end

  // read mux
  always_comb
  begin
    rd_d = 8'h00;
    unique case (i_reg_addr)
      MMUCR_ADDR_RAM_CFG: rd_d = {1'b0, vbank_q, 2'h0, region_q, size_q};
      MMUCR_ADDR_P0_LO: rd_d = p0_lo_q;
      MMUCR_ADDR_P0_HI: rd_d = p0_hi_q;
      MMUCR_ADDR_P1_LO: rd_d = p1_lo_q;
      MMUCR_ADDR_P1_HI: rd_d = p1_hi_q;
      MMUCR_ADDR_VERSION: rd_d = {MEM_BLOCKS, UNIT_VERSION};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_rd_hit <= 1'b0;
    end
    else
    begin
      o_reg_rdata <= rd_sel ? rd_d : 8'h00;
      o_reg_rd_hit <= rd_sel;
    end
  end

  mmucr_page_xlat u_xlat
  (
    .i_addr(i_acc_addr),
    .i_is_ram(i_acc_is_ram),
    .i_p0_page(p0_page_q),
    .i_p1_page(p1_page_q),
    .i_p0_bank(p0_bank_q),
    .i_p1_bank(p1_bank_q),
    .o_page(x_page),
    .o_pg01(x_pg01),
    .o_bank_ovr(x_ovr),
    .o_bank(x_bank)
  );

  // video cycles pass untranslated
  always_comb
  begin
    t_page = i_acc_video ? i_acc_addr[15:8] : x_page;
  end

  mmucr_share_dec u_share
  (
    .i_addr_k(t_page[7:2]),
    .i_size(size_q),
    .i_region(region_q),
    .i_legacy(i_legacy_mode),
    .o_hit(share_hit),
    .o_bottom_en(bottom_en)
  );

  // bank choice: common ram, then video bank, then pointer bank, then config bank
  always_comb
  begin
    use_bank0 = share_hit ||
                (!i_acc_video && bottom_en && x_pg01);
    if (use_bank0)
      bank_d = 1'b0;
    else if (i_acc_video)
      bank_d = vbank_q;
    else if (x_ovr)
      bank_d = x_bank;
    else
      bank_d = i_cfg_bank;
  end

  // translated access, one cycle later; rom and i/o raise no strobe
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_acc_valid <= 1'b0;
      o_taddr_hi <= 8'h00;
      o_bank0_strobe_n <= 1'b1;
      o_bank1_strobe_n <= 1'b1;
    end
    else
    begin
      o_acc_valid <= i_acc_valid;
      o_taddr_hi <= t_page;
      o_bank0_strobe_n <= !(i_acc_valid && i_acc_is_ram && !bank_d);
      o_bank1_strobe_n <= !(i_acc_valid && i_acc_is_ram && bank_d);
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_video_bank <= MMUCR_VBANK_RST;
    else
      o_video_bank <= vbank_q;
  end

  cfg_reset_a: assert property (@(posedge i_core_clk)
    i_sys_rst |=> (size_q == 2'h0) && (region_q == 2'h0) && !vbank_q)
    else $error("config not cleared by reset");

  ptr_reset_a: assert property (@(posedge i_core_clk)
    i_sys_rst |=> (p0_lo_q == 8'h00) && (p0_hi_q == 8'h00) && (p1_lo_q == 8'h00) &&
    (p1_hi_q == 8'h00) && (p0_page_q == 8'h00) && (p1_page_q == MMUCR_P1_PAGE_RST))
    else $error("pointer bytes not cleared by reset");

  cfg_store_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_cfg |=> (size_q == $past(i_reg_wdata[1:0])) && (region_q == $past(i_reg_wdata[3:2])) &&
    (vbank_q == $past(i_reg_wdata[MMUCR_VBANK_BIT])))
    else $error("config write not stored");

  video_out_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_cfg |-> ##2 (o_video_bank == $past(i_reg_wdata[MMUCR_VBANK_BIT], 2)))
    else $error("video bank output does not follow config");

  rd_miss_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_rd && (!i_io_visible || (i_reg_addr < MMUCR_ADDR_RAM_CFG) ||
    (i_reg_addr > MMUCR_ADDR_VERSION))) |=> (!o_reg_rd_hit && (o_reg_rdata == 8'h00)))
    else $error("read outside the register window answered");

  share_strobe_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && i_acc_is_ram && share_hit) |=> (!o_bank0_strobe_n && o_bank1_strobe_n))
    else $error("shared access not steered to bank 0");

  high_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (wr_p0_hi && !wr_p0_lo) |=> $stable(p0_page_q) && $stable(p0_bank_q))
    else $error("high byte write changed relocation");

  low_commit_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_p1_lo |=> (p1_page_q == $past(i_reg_wdata)) && (p1_bank_q == $past(p1_hi_q[0])))
    else $error("low byte write did not commit");

  abs_addr_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && (i_acc_addr[15:1] == 15'h0000)) |=> (o_taddr_hi == 8'h00))
    else $error("absolute byte 0 or 1 moved");

  rom_strobe_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && !i_acc_is_ram) |=> (o_bank0_strobe_n && o_bank1_strobe_n && o_acc_valid))
    else $error("rom access raised a ram strobe");

  idle_strobe_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !i_acc_valid |=> (o_bank0_strobe_n && o_bank1_strobe_n && !o_acc_valid))
    else $error("idle cycle raised a ram strobe");

  rom_swap_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && !i_acc_is_ram && (i_acc_addr[15:9] != 7'h00)) |=>
    (o_taddr_hi == $past(i_acc_addr[15:8])))
    else $error("rom or i/o access back translated");

  page0_move_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && i_acc_is_ram && !i_acc_video && !region_q[MMUCR_REGION_BOTTOM] &&
    !share_hit && (i_acc_addr[15:8] == 8'h00) && (i_acc_addr[7:1] != 7'h00)) |=>
    ((o_taddr_hi == $past(p0_page_q)) && (o_bank1_strobe_n == !$past(p0_bank_q))))
    else $error("page zero access not relocated");

  page1_move_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && i_acc_is_ram && !i_acc_video && !region_q[MMUCR_REGION_BOTTOM] &&
    !share_hit && (i_acc_addr[15:8] == 8'h01)) |=>
    ((o_taddr_hi == $past(p1_page_q)) && (o_bank1_strobe_n == !$past(p1_bank_q))))
    else $error("page one access not relocated");

  legacy_size_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_legacy_mode && (t_page[7:2] >= 6'h01) && (t_page[7:2] < 6'h3F)) |-> !share_hit)
    else $error("shared size used in legacy mode");

  video_bank_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && i_acc_video && i_acc_is_ram && !share_hit) |=>
    ((o_taddr_hi == $past(i_acc_addr[15:8])) && (o_bank1_strobe_n == !$past(vbank_q))))
    else $error("video access translated or misbanked");

  bottom_pg_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && i_acc_is_ram && !i_acc_video && region_q[0] &&
    (i_acc_addr[15:9] == 7'h00)) |=> !o_bank0_strobe_n)
    else $error("page 0/1 left common ram");

  version_rd_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_io_visible && (i_reg_addr == MMUCR_ADDR_VERSION)) |=>
    (o_reg_rd_hit && (o_reg_rdata == {MEM_BLOCKS, UNIT_VERSION})))
    else $error("version register read wrong");

  ptr_rd_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_io_visible && (i_reg_addr == MMUCR_ADDR_P0_HI)) |=>
    (o_reg_rdata == $past(p0_hi_q)))
    else $error("pointer high byte read back wrong");

  swap_back_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_acc_valid && i_acc_is_ram && !i_acc_video && (i_acc_addr[15:8] == p0_page_q) &&
    (p0_page_q > 8'h01)) |=> (o_taddr_hi == 8'h00))
    else $error("target page not swapped back");

endmodule : mmucr_top

// [sim/mmucr_ram_model.sv]
// Purpose: two dynamic ram banks seen through their strobe enables
// Assumes: strobes are low active and sampled on the core clock
// Notes: flags any cycle where both banks are strobed together
`timescale 1ns/1ps
module mmucr_ram_model
(
  input wire logic i_core_clk,        // system clock
  input wire logic i_sys_rst,         // synchronous reset
  input wire logic i_acc_valid,       // translated access valid
  input wire logic i_bank0_strobe_n,  // bank 0 strobe enable
  input wire logic i_bank1_strobe_n,  // bank 1 strobe enable
  output logic o_both_err             // sticky: both banks, or a strobe without valid
);
  // one bank at most answers a cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_both_err <= 1'b0;
    else if ((!i_bank0_strobe_n && !i_bank1_strobe_n) ||
             (!i_acc_valid && (!i_bank0_strobe_n || !i_bank1_strobe_n)))
      o_both_err <= 1'b1;
  end
endmodule : mmucr_ram_model

// [sim/mmu_common_ram_page_relocation_test.sv]
// Purpose: self-checking bench for the common ram and page relocation unit
// Assumes: one-cycle register and access answers
// Notes: second reset in mid-run clears the pointers before the sharing tests
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module mmu_common_ram_page_relocation_test;
  import mmucr_pkg::*;
  localparam logic [3:0] VER = 4'h3;  // arbitrary value
  localparam logic [3:0] BLK = 4'h2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic io_vis = 1'b1;
  logic legacy = 1'b0;
  logic [15:0] raddr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rd_hit;
  logic av = 1'b0;
  logic [15:0] aa = 16'h0000;
  logic a_ram = 1'b0;
  logic a_vid = 1'b0;
  logic cb = 1'b0;
  logic ov;
  logic [7:0] tpg;
  logic b0n;
  logic b1n;
  logic vbank;
  logic both_err;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [6:0] nblk [4] = '{7'h01, 7'h04, 7'h08, 7'h10};

  always #4 clk = ~clk;

  mmucr_top #(.UNIT_VERSION(VER), .MEM_BLOCKS(BLK)) i_dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_io_visible(io_vis), .i_legacy_mode(legacy),
    .i_reg_addr(raddr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_reg_rd_hit(rd_hit), .i_acc_valid(av), .i_acc_addr(aa),
    .i_acc_is_ram(a_ram), .i_acc_video(a_vid), .i_cfg_bank(cb), .o_acc_valid(ov),
    .o_taddr_hi(tpg), .o_bank0_strobe_n(b0n), .o_bank1_strobe_n(b1n),
    .o_video_bank(vbank));

  mmucr_ram_model i_ram (.i_core_clk(clk), .i_sys_rst(rst), .i_acc_valid(ov),
    .i_bank0_strobe_n(b0n), .i_bank1_strobe_n(b1n), .o_both_err(both_err));

  task end_of_test;
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    raddr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [15:0] a, input logic hit, input logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    raddr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rd_hit, hit)
    `CHK(rdata, d)
  endtask : rd_reg

  // chk bit 1 compares the page, bit 0 the strobe pair {bank0_n, bank1_n}
  task acc(input logic [15:0] a, input logic ram, input logic vid, input logic bank,
           input logic [7:0] pg, input logic [1:0] s, input logic [1:0] chk);
    @(posedge clk);
    av <= 1'b1;
    aa <= a;
    a_ram <= ram;
    a_vid <= vid;
    cb <= bank;
    @(posedge clk);
    av <= 1'b0;
    #1;
    `CHK(ov, 1'b1)
    if (chk[1]) `CHK(tpg, pg)
    if (chk[0]) `CHK({b0n, b1n}, s)
  endtask : acc

  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(MMUCR_ADDR_RAM_CFG, 1'b1, 8'h00);
    for (int i = 1; i < 5; i++)
      rd_reg(MMUCR_ADDR_RAM_CFG + 16'(i), 1'b1, 8'h00);
    rd_reg(MMUCR_ADDR_VERSION, 1'b1, {BLK, VER});
    rd_reg(16'hD505, 1'b0, 8'h00);
    `CHK(vbank, 1'b0)
    acc(16'h0010, 1'b1, 1'b0, 1'b1, 8'h00, 2'b01, 2'b11);
    acc(16'h1234, 1'b1, 1'b0, 1'b1, 8'h12, 2'b10, 2'b11);
    wr_reg(MMUCR_ADDR_P0_HI, 8'h01);
    rd_reg(MMUCR_ADDR_P0_HI, 1'b1, 8'h01);
    acc(16'h0010, 1'b1, 1'b0, 1'b1, 8'h00, 2'b01, 2'b11);
    wr_reg(MMUCR_ADDR_P0_LO, 8'h40);
    rd_reg(MMUCR_ADDR_P0_LO, 1'b1, 8'h40);
    acc(16'h0010, 1'b1, 1'b0, 1'b0, 8'h40, 2'b10, 2'b11);
    acc(16'h0001, 1'b1, 1'b0, 1'b0, 8'h00, 2'b00, 2'b10);
    acc(16'h4012, 1'b1, 1'b0, 1'b1, 8'h00, 2'b00, 2'b10);
    acc(16'h4012, 1'b0, 1'b0, 1'b1, 8'h40, 2'b11, 2'b11);
    acc(16'h4012, 1'b1, 1'b1, 1'b1, 8'h40, 2'b01, 2'b11);
    wr_reg(MMUCR_ADDR_P1_HI, 8'hFE);
    wr_reg(MMUCR_ADDR_P1_LO, 8'h41);
    acc(16'h0120, 1'b1, 1'b0, 1'b1, 8'h41, 2'b01, 2'b11);
    wr_reg(MMUCR_ADDR_RAM_CFG, 8'hFF);
    rd_reg(MMUCR_ADDR_RAM_CFG, 1'b1, 8'h4F);
    wr_reg(MMUCR_ADDR_RAM_CFG, 8'h45);
    rd_reg(MMUCR_ADDR_RAM_CFG, 1'b1, 8'h45);
    `CHK(vbank, 1'b1)
    acc(16'h4012, 1'b1, 1'b1, 1'b0, 8'h40, 2'b10, 2'b11);
    acc(16'h0010, 1'b1, 1'b0, 1'b1, 8'h00, 2'b01, 2'b01);
    @(posedge clk) io_vis <= 1'b0;
    wr_reg(MMUCR_ADDR_RAM_CFG, 8'h00);
    rd_reg(MMUCR_ADDR_RAM_CFG, 1'b0, 8'h00);
    @(posedge clk) io_vis <= 1'b1;
    rd_reg(MMUCR_ADDR_RAM_CFG, 1'b1, 8'h45);
    do_reset();
    rd_reg(MMUCR_ADDR_P1_HI, 1'b1, 8'h00);
    rd_reg(MMUCR_ADDR_RAM_CFG, 1'b1, 8'h00);
    acc(16'h0010, 1'b1, 1'b0, 1'b1, 8'h00, 2'b01, 2'b11);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(MMUCR_ADDR_RAM_CFG, {6'h01, 2'(i)});
      acc({nblk[i][5:0] - 6'h01, 10'h000}, 1'b1, 1'b0, 1'b1,
          {nblk[i][5:0] - 6'h01, 2'b00}, 2'b01, 2'b11);
      acc({nblk[i][5:0], 10'h000}, 1'b1, 1'b0, 1'b1,
          {nblk[i][5:0], 2'b00}, 2'b10, 2'b11);
    end
    wr_reg(MMUCR_ADDR_RAM_CFG, 8'h0B);
    acc(16'hC000, 1'b1, 1'b0, 1'b1, 8'hC0, 2'b01, 2'b11);
    acc(16'hBC00, 1'b1, 1'b0, 1'b1, 8'hBC, 2'b10, 2'b11);
    wr_reg(MMUCR_ADDR_RAM_CFG, 8'h0C);
    acc(16'hFC00, 1'b1, 1'b0, 1'b1, 8'hFC, 2'b01, 2'b11);
    acc(16'h0400, 1'b1, 1'b0, 1'b1, 8'h04, 2'b10, 2'b11);
    wr_reg(MMUCR_ADDR_RAM_CFG, 8'h03);
    acc(16'h0800, 1'b1, 1'b0, 1'b1, 8'h08, 2'b10, 2'b11);
    @(posedge clk) legacy <= 1'b1;
    wr_reg(MMUCR_ADDR_RAM_CFG, 8'h07);
    acc(16'h0400, 1'b1, 1'b0, 1'b1, 8'h04, 2'b10, 2'b11);
    @(posedge clk) legacy <= 1'b0;
    `CHK(both_err, 1'b0)
    end_of_test();
  end
endmodule : mmu_common_ram_page_relocation_test
